/* File: adcsc_clkdiv.sv */
// bit_conversion_period divider: one-cycle tick per converted bit
`timescale 1ns/1ps
module adcsc_clkdiv #(
   parameter int unsigned CNT_W = 5
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // control
   input wire logic run_i,
   input wire logic [1:0] sel_i,
   input wire logic internal_oscillator_tick_i,
   // tick out
   output logic bit_tick_o
);
   import adcsc_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] div_w;
   logic src_edge;

   // the counter must hold the largest divisor
   if (CNT_W < 5) begin : g_bad_width
      $error("adcsc_clkdiv: CNT_W too small for divisor 16");
   end

   // divisor and source per select code
   always_comb begin
      unique case (sel_i)
         CSEL_INTOSC4: div_w = CNT_W'(DIV_4);
         CSEL_FOSC4: div_w = CNT_W'(DIV_4);
         CSEL_FOSC8: div_w = CNT_W'(DIV_8);
         CSEL_FOSC16: div_w = CNT_W'(DIV_16);
      endcase
      // internal_oscillator ticks arrive as enables on the one clock
      src_edge = (sel_i == CSEL_INTOSC4) ? internal_oscillator_tick_i : 1'b1;
   end

   // count source edges; >= guards a select change mid-count
   always_ff @(posedge mclk_i) begin
      if (reset_i || !run_i) begin
         cnt_q <= '0;
         bit_tick_o <= 1'b0;
      end else begin
         bit_tick_o <= 1'b0;
         if (src_edge) begin
            if (cnt_q >= div_w - CNT_W'(1)) begin
               cnt_q <= '0;
               bit_tick_o <= 1'b1;
            end else begin
               cnt_q <= cnt_q + CNT_W'(1);
            end
         end
      end
   end

   sequence s_fosc4_gap;
      (bit_tick_o && sel_i == 2'h2) ##1 (run_i && sel_i == 2'h2)[*4];
   endsequence

   sequence s_fosc8_gap;
      (bit_tick_o && sel_i == 2'h1) ##1 (run_i && sel_i == 2'h1)[*8];
   endsequence

   a_fosc4_period: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      s_fosc4_gap |-> bit_tick_o && !$past(bit_tick_o))
      else $error("system clock over 4 gives wrong bit period");

   a_fosc8_period: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      s_fosc8_gap |-> bit_tick_o && !$past(bit_tick_o, 4))
      else $error("system clock over 8 gives wrong bit period");
endmodule : adcsc_clkdiv

/* File: adcsc_pkg.sv */
// package: register map, fields and timing of the converter control block
package adcsc_pkg;
   // register bus
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_RESULT = 4'h4;
   localparam logic [3:0] OFF_STATUS = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // converter_control fields
   localparam int unsigned POS_PWR = 0;
   localparam int unsigned POS_GO = 1;
   localparam int unsigned POS_CHAN = 2;
   localparam int unsigned POS_CSEL = 4;
   localparam int unsigned POS_PINS = 6;
   localparam logic [7:0] CTRL_RESET = 8'hFC;
   localparam logic [1:0] SEL_DEFAULT = 2'h3;
   // status fields
   localparam int unsigned POS_BUSY = 0;
   localparam int unsigned POS_ASLEEP = 1;
   localparam int unsigned POS_TAD_OK = 2;
   localparam int unsigned POS_NRES = 4;
   // conversion clock select codes and divisors
   localparam logic [1:0] CSEL_INTOSC4 = 2'h3;
   localparam logic [1:0] CSEL_FOSC4 = 2'h2;
   localparam logic [1:0] CSEL_FOSC8 = 2'h1;
   localparam logic [1:0] CSEL_FOSC16 = 2'h0;
   localparam logic [4:0] DIV_4 = 5'h04;
   localparam logic [4:0] DIV_8 = 5'h08;
   localparam logic [4:0] DIV_16 = 5'h10;
   // bit_conversion_period window, strictly inside both bounds
   localparam int unsigned MCLK_PERIOD_NS = 8;
   localparam int unsigned TAD_MIN_NS = 500;
   localparam int unsigned TAD_MAX_NS = 50000;
   localparam int unsigned TAD_MIN_CYC = TAD_MIN_NS / MCLK_PERIOD_NS + 1;
   localparam int unsigned TAD_MAX_CYC = TAD_MAX_NS / MCLK_PERIOD_NS;
   localparam int unsigned RES_W = 8;
endpackage : adcsc_pkg

/* File: adcsc_sar.sv */
// successive approximation engine, msb first, one bit per tick
`timescale 1ns/1ps
module adcsc_sar #(
   parameter int unsigned RES_W = 8
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // control
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic bit_tick_i,
   input wire logic compare_i,
   // state and result
   output logic busy_o,
   output logic done_o,
   output logic result_we_o,
   output logic [RES_W-1:0] result_o,
   output logic [RES_W-1:0] trial_code_o,
   output logic [3:0] nres_o
);
   logic [RES_W-1:0] work_q;
   logic [RES_W-1:0] mask_q;
   logic [RES_W-1:0] kept;

   if (RES_W < 2 || RES_W > 15) begin : g_bad_width
      $error("adcsc_sar: RES_W must lie in 2..15");
   end

   // comparator high keeps the bit under trial
   assign kept = compare_i ? trial_code_o : work_q;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         result_we_o <= 1'b0;
         result_o <= '0;
         trial_code_o <= '0;
         work_q <= '0;
         mask_q <= '0;
         nres_o <= 4'h0;
      end else begin
         done_o <= 1'b0;
         result_we_o <= 1'b0;
         if (abort_i && busy_o) begin
            busy_o <= 1'b0;
            trial_code_o <= '0;
            // a partial code is only worth keeping once a bit is known
            if (nres_o != 4'h0) begin
               result_we_o <= 1'b1;
               result_o <= work_q;
            end
         end else if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            work_q <= '0;
            nres_o <= 4'h0;
            mask_q <= {1'b1, {(RES_W-1){1'b0}}};
            trial_code_o <= {1'b1, {(RES_W-1){1'b0}}};
         end else if (busy_o && bit_tick_i) begin
            nres_o <= nres_o + 4'h1;
            if (mask_q[0]) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               result_we_o <= 1'b1;
               result_o <= kept;
               trial_code_o <= '0;
            end else begin
               work_q <= kept;
               mask_q <= mask_q >> 1;
               trial_code_o <= kept | (mask_q >> 1);
            end
         end
      end
   end

   a_msb_first: assert property (
      @(posedge mclk_i) disable iff (reset_i)
      (start_i && !busy_o && !abort_i) |=>
         busy_o && nres_o == 4'h0 && trial_code_o[RES_W-1])
      else $error("conversion did not start on the top bit");
endmodule : adcsc_sar

/* File: adcsc_top.sv */
// converter control: register slave, sleep handling and conversion start
//
// Notes on behaviour
// - no conversion runs or starts while the core sleeps
// - sleep during a conversion clears go and power, aborting it
// - aborted result kept only if at least one bit was resolved
// - sleep entry forces clock and channel select to 11, pins untouched
// - wake or reset sets all selects to 11, clears go and power
// - clock select 11 osc/4, 10 sys/4, 01 sys/8, 00 sys/16
`timescale 1ns/1ps
module adcsc_top (
   // clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // core power state and oscillator enable
   input wire logic sleep_i,
   input wire logic internal_oscillator_tick_i,
   // analog front end
   input wire logic compare_i,
   output logic converter_power_on_o,
   output logic [1:0] channel_select_o,
   output logic [1:0] analog_pin_select_o,
   output logic [adcsc_pkg::RES_W-1:0] trial_code_o,
   // axi4-lite write address and data
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [adcsc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [adcsc_pkg::DATA_W-1:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   // axi4-lite write response
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   output logic [1:0] s_axi_bresp_o,
   // axi4-lite read
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [adcsc_pkg::ADDR_W-1:0] s_axi_araddr_i,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [adcsc_pkg::DATA_W-1:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o
);
   import adcsc_pkg::*;

   logic [7:0] ctl_q;
   logic [RES_W-1:0] result_q;
   logic sleep_q;
   logic sleep_enter;
   logic sleep_wake;
   logic aw_hold_q;
   logic w_hold_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic wr_fire;
   logic wr_ctl;
   logic wr_mapped;
   logic rd_mapped;
   logic sar_start;
   logic sar_abort;
   logic sar_busy;
   logic sar_done;
   logic sar_we;
   logic [RES_W-1:0] sar_result;
   logic [3:0] sar_nres;
   logic bit_tick;
   logic tad_ok;
   int unsigned div_cyc;

   // core power state edges; inputs are synchronous to mclk
   assign sleep_enter = sleep_i && !sleep_q;
   assign sleep_wake = !sleep_i && sleep_q;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         sleep_q <= 1'b0;
      end else begin
         sleep_q <= sleep_i;
      end
   end

   // write address channel, held until the response is taken
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         aw_hold_q <= 1'b0;
         s_axi_awready_o <= 1'b0;
         awaddr_q <= '0;
      end else if (s_axi_awvalid_i && s_axi_awready_o) begin
         aw_hold_q <= 1'b1;
         s_axi_awready_o <= 1'b0;
         awaddr_q <= s_axi_awaddr_i;
      end else if (wr_fire) begin
         aw_hold_q <= 1'b0;
      end else if (!aw_hold_q && !s_axi_bvalid_o) begin
         s_axi_awready_o <= 1'b1;
      end
   end

   // write data channel; only byte lane 0 carries register bits
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         w_hold_q <= 1'b0;
         s_axi_wready_o <= 1'b0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         w_hold_q <= 1'b1;
         s_axi_wready_o <= 1'b0;
         wdata_q <= s_axi_wdata_i[7:0];
         wstrb0_q <= s_axi_wstrb_i[0];
      end else if (wr_fire) begin
         w_hold_q <= 1'b0;
      end else if (!w_hold_q && !s_axi_bvalid_o) begin
         s_axi_wready_o <= 1'b1;
      end
   end

   // address decode; read-only words accept writes and ignore them
   assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid_o;
   assign wr_mapped = (awaddr_q[ADDR_W-1:2] == OFF_CTRL[ADDR_W-1:2]) ||
      (awaddr_q[ADDR_W-1:2] == OFF_RESULT[ADDR_W-1:2]) ||
      (awaddr_q[ADDR_W-1:2] == OFF_STATUS[ADDR_W-1:2]);
   assign rd_mapped = (s_axi_araddr_i[ADDR_W-1:2] == OFF_CTRL[ADDR_W-1:2]) ||
      (s_axi_araddr_i[ADDR_W-1:2] == OFF_RESULT[ADDR_W-1:2]) ||
      (s_axi_araddr_i[ADDR_W-1:2] == OFF_STATUS[ADDR_W-1:2]);
   assign wr_ctl = wr_fire && wstrb0_q &&
      (awaddr_q[ADDR_W-1:2] == OFF_CTRL[ADDR_W-1:2]);

   // write response one cycle after both halves are held
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_o <= 1'b1;
         s_axi_bresp_o <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
         s_axi_bvalid_o <= 1'b0;
      end
   end

   // converter_control: wake beats sleep entry beats software
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         ctl_q <= CTRL_RESET;
      end else if (sleep_wake) begin
         ctl_q <= CTRL_RESET;
      end else if (sleep_enter) begin
         ctl_q[POS_CSEL +: 2] <= SEL_DEFAULT;
         ctl_q[POS_CHAN +: 2] <= SEL_DEFAULT;
         ctl_q[POS_GO] <= 1'b0;
         ctl_q[POS_PWR] <= 1'b0;
      end else if (wr_ctl && !sleep_q) begin
         // a go write wins over a completion in the same cycle
         ctl_q <= wdata_q;
         ctl_q[POS_GO] <= wdata_q[POS_GO] && wdata_q[POS_PWR];
      end else if (sar_done) begin
         ctl_q[POS_GO] <= 1'b0;
      end
   end

   // start only with power on and awake; done blocks a double start
   assign sar_start = ctl_q[POS_GO] && ctl_q[POS_PWR] && !sleep_q &&
      !sleep_i && !sar_busy && !sar_done;
   assign sar_abort = sar_busy && (sleep_enter || !ctl_q[POS_PWR]);

   adcsc_clkdiv #(
      .CNT_W(5)
   ) u_clkdiv (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .run_i(sar_busy),
      .sel_i(ctl_q[POS_CSEL +: 2]),
      .internal_oscillator_tick_i(internal_oscillator_tick_i),
      .bit_tick_o(bit_tick)
   );

   adcsc_sar #(
      .RES_W(RES_W)
   ) u_sar (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .start_i(sar_start),
      .abort_i(sar_abort),
      .bit_tick_i(bit_tick),
      .compare_i(compare_i),
      .busy_o(sar_busy),
      .done_o(sar_done),
      .result_we_o(sar_we),
      .result_o(sar_result),
      .trial_code_o(trial_code_o),
      .nres_o(sar_nres)
   );

   // conversion_result keeps its value across wake, and across sleep unless the sleep abort writes a partial code
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         result_q <= '0;
      end else if (sar_we) begin
         result_q <= sar_result;
      end
   end

   // period check: system clock paths only, the oscillator is trusted
   always_comb begin
      div_cyc = 32'(DIV_4);
      unique case (ctl_q[POS_CSEL +: 2])
         CSEL_INTOSC4: div_cyc = 32'(DIV_4);
         CSEL_FOSC4: div_cyc = 32'(DIV_4);
         CSEL_FOSC8: div_cyc = 32'(DIV_8);
         CSEL_FOSC16: div_cyc = 32'(DIV_16);
      endcase
      tad_ok = (ctl_q[POS_CSEL +: 2] == CSEL_INTOSC4) ||
         (div_cyc >= TAD_MIN_CYC && div_cyc < TAD_MAX_CYC);
   end

   // read channel; data registered at the address handshake
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o <= '0;
         s_axi_rresp_o <= RESP_OKAY;
      end else if (s_axi_arvalid_i && s_axi_arready_o) begin
         s_axi_arready_o <= 1'b0;
         s_axi_rvalid_o <= 1'b1;
         s_axi_rresp_o <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         s_axi_rdata_o <= '0;
         if (s_axi_araddr_i[ADDR_W-1:2] == OFF_CTRL[ADDR_W-1:2]) begin
            s_axi_rdata_o[7:0] <= ctl_q;
         end else if (s_axi_araddr_i[ADDR_W-1:2] ==
            OFF_RESULT[ADDR_W-1:2]) begin
            s_axi_rdata_o[RES_W-1:0] <= result_q;
         end else if (s_axi_araddr_i[ADDR_W-1:2] ==
            OFF_STATUS[ADDR_W-1:2]) begin
            s_axi_rdata_o[POS_BUSY] <= sar_busy;
            s_axi_rdata_o[POS_ASLEEP] <= sleep_q;
            s_axi_rdata_o[POS_TAD_OK] <= tad_ok;
            s_axi_rdata_o[POS_NRES +: 4] <= sar_nres;
         end
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
         s_axi_rvalid_o <= 1'b0;
      end else if (!s_axi_rvalid_o) begin
         s_axi_arready_o <= 1'b1;
      end
   end

   // analog side follows the control register flops
   assign converter_power_on_o = ctl_q[POS_PWR];
   assign channel_select_o = ctl_q[POS_CHAN +: 2];
   assign analog_pin_select_o = ctl_q[POS_PINS +: 2];

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_sleep_entry;
      !sleep_q ##1 sleep_q;
   endsequence

   a_no_sleep_conv: assert property (
      sleep_q |-> !sar_busy && !sar_start)
      else $error("converter busy while core sleeps");

   a_sleep_abort: assert property (
      s_sleep_entry |-> !ctl_q[POS_GO] && !ctl_q[POS_PWR] && !sar_busy)
      else $error("sleep entry left go or power set");

   a_sleep_fields: assert property (
      s_sleep_entry |-> ctl_q[POS_CSEL +: 2] == 2'h3 &&
         ctl_q[POS_CHAN +: 2] == 2'h3 &&
         ctl_q[POS_PINS +: 2] == $past(ctl_q[POS_PINS +: 2]))
      else $error("sleep entry fields wrong");

   a_wake_fields: assert property (
      $fell(sleep_q) |-> ctl_q == 8'hFC)
      else $error("wake did not restore control defaults");

   a_reset_fields: assert property (
      $past(reset_i) |-> ctl_q == 8'hFC && !s_axi_bvalid_o)
      else $error("reset did not restore control defaults");

   a_partial_keep: assert property (
      (sar_abort && sar_nres == 4'h0) |-> ##1 !sar_we ##1 $stable(result_q))
      else $error("result changed after abort with no bit resolved");

   a_done_clears: assert property (
      (sar_done && !wr_ctl && !sleep_enter && !sleep_wake) |=>
         !ctl_q[POS_GO] ##1 !sar_busy)
      else $error("go not cleared after completion");
endmodule : adcsc_top

/* File: adcsc_top_tb.sv */
// testbench: register access, conversions and sleep handling of adcsc_top
`timescale 1ns/1ps
module adcsc_top_tb;
   import adcsc_pkg::*;
   // clock, reset and core inputs
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic sleep_i = 1'b0;
   logic internal_oscillator_tick_i = 1'b0;
   logic compare_i = 1'b0;
   logic pwr_o;
   logic [1:0] chan_o, pins_o;
   logic [7:0] trial_o;
   // register bus
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
   logic [31:0] wdata = 32'h00000000, rdata;
   logic [1:0] bresp, rresp;
   // bench state
   int num_errors = 0;
   int checks_done = 0;
   int busy_cyc = 0;
   logic [7:0] target = 8'h00;
   logic [1:0] osc_div = 2'h0;
   logic [3:0] lane_en = 4'hF;

   always #4 mclk_i = ~mclk_i;

   adcsc_top dut (.mclk_i(mclk_i), .reset_i(reset_i), .sleep_i(sleep_i),
      .internal_oscillator_tick_i(internal_oscillator_tick_i), .compare_i(compare_i),
      .converter_power_on_o(pwr_o), .channel_select_o(chan_o),
      .analog_pin_select_o(pins_o), .trial_code_o(trial_o),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(wstrb), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp));

   // comparator: analog level sits at target, lags one cycle behind the code
   always @(posedge mclk_i) compare_i <= (target >= trial_o);
   // oscillator pulse every third clock, unrelated to the bit divisor
   always @(posedge mclk_i) begin
      osc_div <= (osc_div == 2'h2) ? 2'h0 : osc_div + 2'h1;
      internal_oscillator_tick_i <= (osc_div == 2'h2);
   end
   // a nonzero trial code marks a conversion cycle
   always @(posedge mclk_i) if (trial_o !== 8'h00) busy_cyc = busy_cyc + 1;

   task automatic chk(input string name, input logic [31:0] e,
                      input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask : chk

   task automatic axi_write(input logic [3:0] a, input logic [7:0] d,
                            output logic [1:0] resp);
      int n;
      n = 0;
      resp = 2'h1;
      @(posedge mclk_i);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= {24'h000000, d};
      wstrb <= lane_en;
      bready <= 1'b1;
      // each channel is released only at the edge that takes it
      while (n < 60) begin
         @(posedge mclk_i);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            resp = bresp;
            bready <= 1'b0;
            n = 99;
         end
      end
      chk("write answered", 1, n == 99);
   endtask : axi_write

   task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                           output logic [1:0] resp);
      int n;
      n = 0;
      resp = 2'h1;
      d = 32'hFFFFFFFF;
      @(posedge mclk_i);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (n < 60) begin
         @(posedge mclk_i);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            resp = rresp;
            rready <= 1'b0;
            n = 99;
         end
      end
      chk("read answered", 1, n == 99);
   endtask : axi_read

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [1:0] r;
      axi_write(a, d, r);
      chk("write resp", RESP_OKAY, r);
   endtask : wr

   task automatic rd_chk(input string name, input logic [3:0] a,
                         input logic [7:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_read(a, d, r);
      chk(name, {24'h000000, e}, d);
      chk("read resp", RESP_OKAY, r);
   endtask : rd_chk

   // full conversion with a given clock select; returns its length
   task automatic run_conv(input logic [1:0] csel, input logic [7:0] tgt,
                           output int cyc);
      logic [31:0] d;
      logic [1:0] r;
      int n;
      target = tgt;
      busy_cyc = 0;
      n = 0;
      wr(OFF_CTRL, {2'b00, csel, 2'b01, 2'b11});
      d = 32'h2;
      while (d[1] !== 1'b0 && n < 100) begin
         axi_read(OFF_CTRL, d, r);
         n++;
      end
      repeat (2) @(posedge mclk_i);
      rd_chk("result", OFF_RESULT, tgt);
      rd_chk("control", OFF_CTRL, {2'b00, csel, 2'b01, 2'b01});
      chk("channel", 2'b01, chan_o);
      chk("pins", 2'b00, pins_o);
      chk("power", 1'b1, pwr_o);
      // at this clock only the oscillator path gives a legal bit period
      axi_read(OFF_STATUS, d, r);
      chk("period ok", csel == CSEL_INTOSC4, d[POS_TAD_OK]);
      cyc = busy_cyc;
   endtask : run_conv

   task automatic clock_selects;
      int c4, c8, c16, ci;
      run_conv(CSEL_FOSC4, 8'hA5, c4);
      run_conv(CSEL_FOSC8, 8'h3C, c8);
      run_conv(CSEL_FOSC16, 8'h81, c16);
      run_conv(CSEL_INTOSC4, 8'h5A, ci);
      chk("div8 minus div4", 32'd32, c8 - c4);
      chk("div16 minus div8", 32'd64, c16 - c8);
      chk("osc length", 1, (ci > c8 + 24) && (ci < c16));
   endtask : clock_selects

   // sleep after two bits: partial result, forced selects, writes ignored
   task automatic sleep_abort;
      logic [31:0] d;
      logic [1:0] r;
      logic [3:0] nres;
      target = 8'hC3;
      wr(OFF_CTRL, {2'b01, CSEL_FOSC16, 2'b10, 2'b11});
      repeat (40) @(posedge mclk_i);
      sleep_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      chk("power", 1'b0, pwr_o);
      chk("channel", SEL_DEFAULT, chan_o);
      chk("pins", 2'b01, pins_o);
      rd_chk("control", OFF_CTRL, 8'h7C);
      axi_read(OFF_STATUS, d, r);
      nres = d[7:4];
      chk("asleep", 1'b1, d[1]);
      chk("bits resolved", 1, nres != 4'h0);
      rd_chk("partial", OFF_RESULT, target & ~(8'hFF >> nres));
      wr(OFF_CTRL, 8'h03);
      repeat (20) @(posedge mclk_i);
      chk("trial code", 8'h00, trial_o);
      rd_chk("control", OFF_CTRL, 8'h7C);
      sleep_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rd_chk("control", OFF_CTRL, CTRL_RESET);
      chk("pins", SEL_DEFAULT, pins_o);
   endtask : sleep_abort

   // sleep before the first bit: result keeps its old value
   task automatic sleep_early;
      logic [31:0] old;
      logic [31:0] d;
      logic [1:0] r;
      axi_read(OFF_RESULT, old, r);
      target = 8'h5A;
      wr(OFF_CTRL, {2'b00, CSEL_FOSC16, 2'b00, 2'b11});
      repeat (3) @(posedge mclk_i);
      sleep_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      axi_read(OFF_STATUS, d, r);
      chk("bits resolved", 4'h0, d[7:4]);
      rd_chk("kept result", OFF_RESULT, old[7:0]);
      sleep_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
   endtask : sleep_early

   // refused accesses, then a reset with power on
   task automatic misc_and_reset;
      logic [31:0] d;
      logic [1:0] r;
      wr(OFF_CTRL, 8'hFE);
      rd_chk("go without power", OFF_CTRL, 8'hFC);
      // lane 0 strobe low: the control write must be dropped
      lane_en = 4'hE;
      wr(OFF_CTRL, 8'h01);
      lane_en = 4'hF;
      rd_chk("strobe off", OFF_CTRL, 8'hFC);
      wr(OFF_RESULT, 8'h77);
      rd_chk("write ignored", OFF_RESULT, 8'hC0);
      // power cleared by software before the first bit aborts cleanly
      target = 8'h96;
      wr(OFF_CTRL, {2'b00, CSEL_FOSC16, 2'b00, 2'b11});
      axi_read(OFF_STATUS, d, r);
      chk("busy", 1'b1, d[POS_BUSY]);
      wr(OFF_CTRL, 8'h00);
      rd_chk("status", OFF_STATUS, 8'h00);
      rd_chk("kept result", OFF_RESULT, 8'hC0);
      chk("trial code", 8'h00, trial_o);
      axi_read(4'hC, d, r);
      chk("unmapped read", RESP_SLVERR, r);
      chk("unmapped data", 32'h0, d);
      axi_write(4'hC, 8'h11, r);
      chk("unmapped write", RESP_SLVERR, r);
      wr(OFF_CTRL, 8'h01);
      chk("power", 1'b1, pwr_o);
      @(posedge mclk_i);
      reset_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      chk("power", 1'b0, pwr_o);
      chk("channel", SEL_DEFAULT, chan_o);
      rd_chk("control", OFF_CTRL, CTRL_RESET);
   endtask : misc_and_reset

   task automatic close_out;
      if (num_errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : close_out

   // main sequence
   initial begin
      repeat (2) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      chk("power", 1'b0, pwr_o);
      chk("pins", SEL_DEFAULT, pins_o);
      rd_chk("control", OFF_CTRL, CTRL_RESET);
      rd_chk("result", OFF_RESULT, 8'h00);
      clock_selects();
      sleep_abort();
      sleep_early();
      misc_and_reset();
      close_out();
   end

   // watchdog: the whole run needs a few hundred cycles
   initial begin
      #400000;
      num_errors++;
      close_out();
   end
endmodule : adcsc_top_tb
